// ### hw/rsc_config_regs.sv
// Transceiver synthesiser and receive configuration bank with AXI4-Lite slave
//
// Function
// - Integer LO count, bits 7:4, resets nine
// - Twelve-bit unsigned fraction over two registers
// - LO frequency from integer plus 53, fraction
// - Carrier is LO divided by band ratio
// - Delay disabled gives fixed 105.5 us
// - Delay code selects start-up wait time
// - Delay applies only on entry into run
// - Drive strength bits for three pin groups
// - IF bandwidth bit selects filter and IF
// - Front amplifier gain two bits, 7:6
// - Bit-rate filter cutoff in bits 4:1
// - Detection and data-pin enables in function register
// - HF detector enable only with delay detection
// - Digital block enable, resets enabled
// - Zero write resets detectors until chip-select rises
// - Detection reset bit reads last written value
// - Status bits select sleep, standby, run with pin
// - Frequency change releases held lock indication
`timescale 1ns/100ps
module rsc_config_regs
    import rsc_pkg::*;
#(
    parameter int DLY0_CYC = RSC_DLY0_CYC,
    parameter int DLY1_CYC = RSC_DLY1_CYC,
    parameter int DLY2_CYC = RSC_DLY2_CYC,
    parameter int DLY3_CYC = RSC_DLY3_CYC,
    parameter int DLY4_CYC = RSC_DLY4_CYC
)
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Device pins
    input  wire logic        chip_enable_pin,
    input  wire logic        spi_cs_n,
    input  wire logic        pll_lock,
    // Synthesiser settings
    output logic [3:0]       lo_integer_count,
    output logic [11:0]      lo_fraction_count,
    output logic             lock_held,
    // Start-up and drive
    output logic [1:0]       pwr_state,
    output logic             run_active,
    output logic             data_pin_drive,
    output logic             sdo_pin_drive,
    output logic             monitor_pin_drive,
    // Receive front end
    output logic [1:0]       front_amp_gain,
    output logic             if_bandwidth_sel,
    output logic [3:0]       bitrate_filter_cutoff,
    // Receive functions
    output logic             rssi_det_on,
    output logic             preamble_det_on,
    output logic             noise_det_on,
    output logic             hf_det_on,
    output logic             data_pin_ctrl_on,
    output logic             digital_block_on,
    output logic             detectors_held
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]  freq_hi_r;
    logic [7:0]  freq_lo_r;
    logic [7:0]  delay_r;
    logic [7:0]  frontend_r;
    logic [7:0]  function_r;
    logic [7:0]  status_r;
    logic        pulse_count_sel_r;
    logic        det_hold_r;
    logic        cs_n_d_r;
    logic        lock_r;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held_r;
    logic [7:0]  aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        wr_fire;
    logic        wr_en;
    logic [7:0]  wr_byte;
    logic        wr_hit_hi;
    logic        wr_hit_lo;
    logic        wr_hit_dly;
    logic        wr_hit_fe;
    logic        wr_hit_fn;
    logic        wr_hit_st;
    logic        wr_hit_sel;
    logic        wr_mapped;
    logic [5:0]  wr_idx;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
    assign wr_idx        = aw_addr_r[7:2];
    assign wr_hit_hi     = (wr_idx == RSC_OFF_FREQ_HI[5:0]);
    assign wr_hit_lo     = (wr_idx == RSC_OFF_FREQ_LO[5:0]);
    assign wr_hit_dly    = (wr_idx == RSC_OFF_DELAY[5:0]);
    assign wr_hit_fe     = (wr_idx == RSC_OFF_FRONTEND[5:0]);
    assign wr_hit_fn     = (wr_idx == RSC_OFF_FUNCTION[5:0]);
    assign wr_hit_st     = (wr_idx == RSC_OFF_STATUS[5:0]);
    assign wr_hit_sel    = (wr_idx == RSC_OFF_DETSEL[5:0]);
    assign wr_mapped     = wr_hit_hi | wr_hit_lo | wr_hit_dly | wr_hit_fe
                         | wr_hit_fn | wr_hit_st | wr_hit_sel;
    assign wr_en         = wr_fire && wr_mapped && w_strb_r[0];
    // Each register is the low byte of its own word; lane 0 must be strobed
    assign wr_byte       = w_data_r[7:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RSC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r  <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_strb_r  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ------------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------------
    logic cs_rise;
    logic freq_change;

    assign cs_rise     = spi_cs_n && !cs_n_d_r;
    assign freq_change = wr_en && ((wr_hit_hi && wr_byte != freq_hi_r)
                       || (wr_hit_lo && wr_byte != freq_lo_r));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            freq_hi_r         <= RSC_RST_FREQ_HI;
            freq_lo_r         <= RSC_RST_FREQ_LO;
            delay_r           <= RSC_RST_DELAY;
            frontend_r        <= RSC_RST_FRONTEND;
            function_r        <= RSC_RST_FUNCTION;
            status_r          <= RSC_RST_STATUS;
            pulse_count_sel_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (wr_hit_hi)
                freq_hi_r <= wr_byte;
            if (wr_hit_lo)
                freq_lo_r <= wr_byte;
            if (wr_hit_dly)
                delay_r <= wr_byte;
            if (wr_hit_fe)
                frontend_r <= wr_byte;
            if (wr_hit_fn)
                function_r <= wr_byte;
            if (wr_hit_st)
                status_r <= wr_byte;
            if (wr_hit_sel)
                pulse_count_sel_r <= wr_byte[RSC_B_SEL_PULSE];
        end
    end

    // Detector hold: set by a complete zero write, released by CS rising
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            det_hold_r <= 1'b0;
            cs_n_d_r   <= 1'b1;
        end
        else
        begin
            cs_n_d_r <= spi_cs_n;
            if (wr_en && wr_hit_fn && !wr_byte[RSC_B_DET_RSTN])
                det_hold_r <= 1'b1;
            else if (cs_rise)
                det_hold_r <= 1'b0;
        end
    end

    // Held lock indication for the transmit amplifier
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lock_r <= 1'b0;
        else if (freq_change || !run_active)
            lock_r <= 1'b0;
        else if (pll_lock)
            lock_r <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [7:0]  rd_byte;
    logic        rd_mapped;
    logic [5:0]  rd_idx;

    assign s_axi_arready = !rvalid_r;
    assign rd_idx    = s_axi_araddr[7:2];
    assign rd_mapped = (rd_idx == RSC_OFF_FREQ_HI[5:0]) || (rd_idx == RSC_OFF_FREQ_LO[5:0])
                    || (rd_idx == RSC_OFF_DELAY[5:0]) || (rd_idx == RSC_OFF_FRONTEND[5:0])
                    || (rd_idx == RSC_OFF_FUNCTION[5:0]) || (rd_idx == RSC_OFF_STATUS[5:0])
                    || (rd_idx == RSC_OFF_DETSEL[5:0]);

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (rd_idx)
            RSC_OFF_FREQ_HI[5:0]:  rd_byte = freq_hi_r;
            RSC_OFF_FREQ_LO[5:0]:  rd_byte = freq_lo_r;
            RSC_OFF_DELAY[5:0]:    rd_byte = delay_r;
            RSC_OFF_FRONTEND[5:0]: rd_byte = frontend_r;
            RSC_OFF_FUNCTION[5:0]: rd_byte = function_r;
            RSC_OFF_STATUS[5:0]:   rd_byte = status_r;
            RSC_OFF_DETSEL[5:0]:   rd_byte = {7'h00, pulse_count_sel_r};
            default:          rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= RSC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rd_byte};
            rresp_r  <= rd_mapped ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ------------------------------------------------------------------
    // Start-up sequencing
    // ------------------------------------------------------------------
    logic awake;

    // Status bits honoured only while the enable pin is high
    assign awake = chip_enable_pin & status_r[RSC_B_ST_SLEEPN];

    rsc_startup_timer #(
        .DLY0_CYC (DLY0_CYC),
        .DLY1_CYC (DLY1_CYC),
        .DLY2_CYC (DLY2_CYC),
        .DLY3_CYC (DLY3_CYC),
        .DLY4_CYC (DLY4_CYC)
    ) u_timer (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .awake             (awake),
        .run_select        (status_r[RSC_B_ST_RUN]),
        .dly_en            (delay_r[RSC_B_DLY_EN]),
        .startup_wait_code (delay_r[RSC_B_DLY_LSB +: 3]),
        .pwr_state         (pwr_state),
        .run_active        (run_active)
    );

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------
    // Oscillator = (integer + 53) * ref + fraction * ref / 3032; carrier by band ratio
    assign lo_integer_count      = freq_hi_r[7:4];
    assign lo_fraction_count     = {freq_hi_r[3:0], freq_lo_r};
    assign lock_held             = lock_r;
    assign data_pin_drive        = delay_r[RSC_B_DRV_DATA];
    assign sdo_pin_drive         = delay_r[RSC_B_DRV_SDO];
    assign monitor_pin_drive     = delay_r[RSC_B_DRV_MON];
    assign front_amp_gain        = frontend_r[RSC_B_GAIN_LSB +: 2];
    assign if_bandwidth_sel      = frontend_r[RSC_B_IF_BANDWIDTH_SEL];
    assign bitrate_filter_cutoff = frontend_r[RSC_B_BRF_LSB +: 4];
    assign rssi_det_on           = function_r[RSC_B_RSSI_EN];
    assign preamble_det_on       = function_r[RSC_B_PRE_EN];
    assign noise_det_on          = function_r[RSC_B_NOISE_EN];
    assign hf_det_on             = function_r[RSC_B_HF_EN] & !pulse_count_sel_r;
    assign data_pin_ctrl_on      = function_r[RSC_B_DOUT_EN];
    assign digital_block_on      = function_r[RSC_B_DIG_EN];
    assign detectors_held        = det_hold_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_hold_on_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_en && wr_hit_fn && !wr_byte[RSC_B_DET_RSTN]) |=> detectors_held)
        else $error("detector hold not set by zero write");
    a_resume_cs: assert property (@(posedge aclk) disable iff (!aresetn)
        (cs_rise && !(wr_en && wr_hit_fn)) |=> !detectors_held)
        else $error("detectors not resumed on chip-select rise");
    a_readback_fn: assert property (@(posedge aclk) disable iff (!aresetn)
        (cs_rise && !wr_en) |=> $stable(function_r))
        else $error("function register changed on chip-select rise");
    a_freq_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
        freq_change |=> !lock_held)
        else $error("lock held after frequency change");
    a_hf_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        pulse_count_sel_r |-> !hf_det_on)
        else $error("hf detector active under pulse counting");
    a_sleep_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        !chip_enable_pin |=> !run_active)
        else $error("run while enable pin low");
    a_fixed_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(pwr_state == RSC_PWR_WAIT) && !delay_r[RSC_B_DLY_EN]
         && u_timer.cnt_r == 20'(DLY0_CYC - 1)) or !$rose(pwr_state == RSC_PWR_WAIT)
         or delay_r[RSC_B_DLY_EN])
        else $error("fixed start-up delay not loaded");
    a_run_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwr_state == RSC_PWR_STBY) ##1 (pwr_state == RSC_PWR_RUN) |-> 1'b0)
        else $error("run entered without start-up delay");
    a_integer_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_en && wr_hit_hi) |=> lo_integer_count == $past(wr_byte[7:4]))
        else $error("integer count not updated");
endmodule

// ### hw/rsc_pkg.sv
// Package of register map, field positions, reset values and timing for the config bank
package rsc_pkg;
    // Register indices; each register is one word at byte address four times its index
    localparam logic [7:0] RSC_OFF_FREQ_HI  = 8'h0b;
    localparam logic [7:0] RSC_OFF_FREQ_LO  = 8'h0c;
    localparam logic [7:0] RSC_OFF_DELAY    = 8'h0d;
    localparam logic [7:0] RSC_OFF_FRONTEND = 8'h0e;
    localparam logic [7:0] RSC_OFF_FUNCTION = 8'h0f;
    localparam logic [7:0] RSC_OFF_STATUS   = 8'h0a;
    localparam logic [7:0] RSC_OFF_DETSEL   = 8'h10;
    // Reset values
    localparam logic [7:0] RSC_RST_FREQ_HI  = 8'h93;
    localparam logic [7:0] RSC_RST_FREQ_LO  = 8'hf8;
    localparam logic [7:0] RSC_RST_DELAY    = 8'h00;
    localparam logic [7:0] RSC_RST_FRONTEND = 8'h12;
    localparam logic [7:0] RSC_RST_FUNCTION = 8'h07;
    localparam logic [7:0] RSC_RST_STATUS   = 8'h40;
    // Field positions
    localparam int RSC_B_DLY_EN   = 7;
    localparam int RSC_B_DLY_LSB  = 4;
    localparam int RSC_B_DRV_DATA = 3;
    localparam int RSC_B_DRV_SDO  = 2;
    localparam int RSC_B_DRV_MON  = 1;
    localparam int RSC_B_GAIN_LSB = 6;
    localparam int RSC_B_IF_BANDWIDTH_SEL     = 5;
    localparam int RSC_B_BRF_LSB  = 1;
    localparam int RSC_B_RSSI_EN  = 7;
    localparam int RSC_B_PRE_EN   = 6;
    localparam int RSC_B_NOISE_EN = 5;
    localparam int RSC_B_HF_EN    = 4;
    localparam int RSC_B_DOUT_EN  = 3;
    localparam int RSC_B_DIG_EN   = 2;
    localparam int RSC_B_DET_RSTN = 1;
    localparam int RSC_B_SEL_PULSE = 0;
    localparam int RSC_B_ST_SLEEPN = 7;
    localparam int RSC_B_ST_RUN    = 6;
    // Oscillator formula
    localparam int RSC_NC_OFFSET  = 53;
    localparam int RSC_STEP_DIV   = 3032;
    // Start-up delays in ns and cycles at 100 MHz
    localparam int RSC_CLK_NS     = 10;
    localparam int RSC_DLY0_NS    = 105500;
    localparam int RSC_DLY1_NS    = 211100;
    localparam int RSC_DLY2_NS    = 316500;
    localparam int RSC_DLY3_NS    = 527500;
    localparam int RSC_DLY4_NS    = 949500;
    localparam int RSC_DLY0_CYC   = (RSC_DLY0_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    localparam int RSC_DLY1_CYC   = (RSC_DLY1_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    localparam int RSC_DLY2_CYC   = (RSC_DLY2_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    localparam int RSC_DLY3_CYC   = (RSC_DLY3_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    localparam int RSC_DLY4_CYC   = (RSC_DLY4_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    // Bus answers
    localparam logic [1:0] RSC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RSC_RESP_SLVERR = 2'b10;
    // Power states
    typedef enum logic [1:0]
    {
        RSC_PWR_SLEEP = 2'b00,
        RSC_PWR_WAIT  = 2'b01,
        RSC_PWR_RUN   = 2'b11,
        RSC_PWR_STBY  = 2'b10
    } rsc_pwr_e;
endpackage

// ### hw/rsc_startup_timer.sv
// Start-up delay sequencer for entry into run
`timescale 1ns/100ps
module rsc_startup_timer
    import rsc_pkg::*;
#(
    parameter int DLY0_CYC = RSC_DLY0_CYC,
    parameter int DLY1_CYC = RSC_DLY1_CYC,
    parameter int DLY2_CYC = RSC_DLY2_CYC,
    parameter int DLY3_CYC = RSC_DLY3_CYC,
    parameter int DLY4_CYC = RSC_DLY4_CYC
)
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       awake,
    input  wire logic       run_select,
    input  wire logic       dly_en,
    input  wire logic [2:0] startup_wait_code,
    // Status
    output logic [1:0]      pwr_state,
    output logic            run_active
);
    rsc_pwr_e    state_r;
    rsc_pwr_e    state_nxt;
    logic [19:0] cnt_r;
    logic [19:0] cnt_nxt;
    logic [19:0] load_val;
    logic        want_run;

    assign want_run = awake & run_select;

    // Delay code lookup, sampled at the moment of entry only
    always_comb
    begin
        load_val = 20'(DLY0_CYC - 1);
        if (dly_en)
        begin
            unique case (startup_wait_code)
                3'b001:  load_val = 20'(DLY1_CYC - 1);
                3'b010:  load_val = 20'(DLY2_CYC - 1);
                3'b011:  load_val = 20'(DLY3_CYC - 1);
                3'b100:  load_val = 20'(DLY4_CYC - 1);
                default: load_val = 20'(DLY0_CYC - 1);
            endcase
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            RSC_PWR_SLEEP, RSC_PWR_STBY:
            begin
                if (want_run)
                begin
                    state_nxt = RSC_PWR_WAIT;
                    cnt_nxt   = load_val;
                end
                else if (awake)
                    state_nxt = RSC_PWR_STBY;
                else
                    state_nxt = RSC_PWR_SLEEP;
            end
            RSC_PWR_WAIT:
            begin
                if (!awake)
                    state_nxt = RSC_PWR_SLEEP;
                else if (!run_select)
                    state_nxt = RSC_PWR_STBY;
                else if (cnt_r == 20'h00000)
                    state_nxt = RSC_PWR_RUN;
                else
                    cnt_nxt = cnt_r - 20'h00001;
            end
            RSC_PWR_RUN:
            begin
                if (!awake)
                    state_nxt = RSC_PWR_SLEEP;
                else if (!run_select)
                    state_nxt = RSC_PWR_STBY;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= RSC_PWR_SLEEP;
            cnt_r   <= 20'h00000;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign pwr_state  = state_r;
    assign run_active = (state_r == RSC_PWR_RUN);
endmodule

// ### testbench/rsc_host_pins.sv
// Host-side pin model: chip select, enable pin and lock input
`timescale 1ns/100ps
module rsc_host_pins
(
    // Clock
    input  wire logic aclk,
    // Pins toward the bank
    output logic      spi_cs_n,
    output logic      chip_enable_pin,
    output logic      pll_lock
);
    initial
    begin
        spi_cs_n = 1'b1;
        chip_enable_pin = 1'b0;
        pll_lock = 1'b0;
    end
    // Select frame; its rising edge ends a detector hold
    task automatic cs_frame(input int n);
        @(posedge aclk) spi_cs_n <= 1'b0;
        repeat (n) @(posedge aclk);
        spi_cs_n <= 1'b1;
    endtask
    task automatic set_pins(input logic en, input logic lk);
        @(posedge aclk) chip_enable_pin <= en;
        pll_lock <= lk;
    endtask
endmodule

// ### testbench/rsc_config_regs_tb.sv
// Self-checking bench for the synthesiser and receive configuration bank
`timescale 1ns/100ps
module rsc_config_regs_tb;
    import rsc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d;} rsc_row_s;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb = 4'h0, lo_integer_count, bitrate_filter_cutoff;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pwr_state, front_amp_gain, resp;
    logic        spi_cs_n, chip_enable_pin, pll_lock, lock_held, run_active, detectors_held;
    logic        data_pin_drive, sdo_pin_drive, monitor_pin_drive, if_bandwidth_sel;
    logic        rssi_det_on, preamble_det_on, noise_det_on, hf_det_on;
    logic        data_pin_ctrl_on, digital_block_on;
    logic [11:0] lo_fraction_count;
    int          mismatches = 0, check_count = 0, cyc = 0, n;
    rsc_row_s    rows [5] = '{'{8'h0b, 8'ha5}, '{8'h0c, 8'h3c}, '{8'h0d, 8'h0a},
                             '{8'h0e, 8'hea}, '{8'h0f, 8'hfb}};
    logic [7:0]  rsts [5] = '{RSC_RST_FREQ_HI, RSC_RST_FREQ_LO, RSC_RST_DELAY,
                             RSC_RST_FRONTEND, RSC_RST_FUNCTION};

    rsc_config_regs #(.DLY0_CYC(5), .DLY1_CYC(10), .DLY2_CYC(15), .DLY3_CYC(20), .DLY4_CYC(30))
        i_rsc_config_regs (.*);
    rsc_host_pins i_rsc_host_pins (.*);

    initial
    begin
        forever #5 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= {a[5:0], 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= {a[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    task automatic wait_run();
        n = 0;
        while (!run_active && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++)
        begin
            rd(rows[i].a);
            chk("reset value", rsts[i], rd_d);
        end
        chk("integer count", 9, lo_integer_count);
        chk("fraction count", 1016, lo_fraction_count);
        chk("digital block", 1, digital_block_on);
        for (int i = 0; i < 5; i++)
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("readback", rows[i].d, rd_d);
        end
        chk("synth", 16'ha53c, {lo_integer_count, lo_fraction_count});
        chk("drive", 3'b101, {data_pin_drive, sdo_pin_drive, monitor_pin_drive});
        chk("front", 7'h75, {front_amp_gain, if_bandwidth_sel, bitrate_filter_cutoff});
        chk("enables", 5'h1e, {rssi_det_on, preamble_det_on, noise_det_on,
            data_pin_ctrl_on, digital_block_on});
        chk("hf detector", 1, hf_det_on);
        // Detector hold until chip select rises
        wr(8'h0f, 8'hf9);
        @(posedge aclk);
        chk("held", 1, detectors_held);
        i_rsc_host_pins.cs_frame(3);
        repeat (2) @(posedge aclk);
        chk("released", 0, detectors_held);
        rd(8'h0f);
        chk("reset bit", 8'hf9, rd_d);
        rd(8'h20);
        chk("unmapped read resp", RSC_RESP_SLVERR, resp);
        chk("unmapped read data", 0, rd_d);
        wr(8'h21, 8'h55);
        chk("unmapped write", RSC_RESP_SLVERR, resp);
        wr(8'h10, 8'h01);
        chk("hf pulse count", 0, hf_det_on);
        // Start-up waits and lock hold
        i_rsc_host_pins.set_pins(1'b1, 1'b0);
        wr(8'h0d, 8'h90);
        wr(RSC_OFF_STATUS, 8'hc0);
        wait_run();
        chk("wait code 1", 1, n >= 10 && n <= 14);
        i_rsc_host_pins.set_pins(1'b1, 1'b1);
        repeat (2) @(posedge aclk);
        chk("lock held", 1, lock_held);
        i_rsc_host_pins.set_pins(1'b1, 1'b0);
        wr(8'h0c, 8'h3d);
        @(posedge aclk);
        chk("lock freed", 0, lock_held);
        wr(8'h0d, 8'hc0);
        repeat (3) @(posedge aclk);
        chk("still run", 1, run_active);
        wr(RSC_OFF_STATUS, 8'h80);
        repeat (2) @(posedge aclk);
        chk("standby", RSC_PWR_STBY, pwr_state);
        wr(RSC_OFF_STATUS, 8'hc0);
        wait_run();
        chk("wait code 4", 1, n >= 30 && n <= 34);
        wr(8'h0d, 8'h70);
        i_rsc_host_pins.set_pins(1'b0, 1'b0);
        repeat (2) @(posedge aclk);
        chk("pin sleep", RSC_PWR_SLEEP, pwr_state);
        i_rsc_host_pins.set_pins(1'b1, 1'b0);
        wait_run();
        chk("fixed wait", 1, n >= 5 && n <= 9);
        conclude();
    end
endmodule
